/* File: common/cct_defs.vh */
`ifndef CCT_DEFS_VH
`define CCT_DEFS_VH

////////////////////////////////////////////////////////////////////////
// register addresses on the 8-bit peripheral bus
`define CCT_A_IRQ_EN   4'h0
`define CCT_A_FLAGS    4'h1
`define CCT_A_FRC_H    4'h2
`define CCT_A_FRC_L    4'h3
`define CCT_A_OCR_H    4'h4
`define CCT_A_OCR_L    4'h5
`define CCT_A_TCTL     4'h6
`define CCT_A_OCTL     4'h7
`define CCT_A_ICA_H    4'h8
`define CCT_A_ICA_L    4'h9
`define CCT_A_ICB_H    4'ha
`define CCT_A_ICB_L    4'hb
`define CCT_A_ICC_H    4'hc
`define CCT_A_ICC_L    4'hd
`define CCT_A_ICD_H    4'he
`define CCT_A_ICD_L    4'hf

////////////////////////////////////////////////////////////////////////
// reset values
`define CCT_RST_TCTL   8'h00
`define CCT_RST_OCTL   8'he0
`define CCT_RST_FLAGS  8'h00
`define CCT_RST_IRQ_EN 8'h00
`define CCT_RST_16     16'h0000
`define CCT_MAX_16     16'hffff
`define CCT_OCTL_FIXED 3'h7

////////////////////////////////////////////////////////////////////////
// timer_control fields
`define CCT_TC_EDGE_A  7
`define CCT_TC_BUF_A   3
`define CCT_TC_BUF_B   2
`define CCT_TC_CKS_HI  1
`define CCT_TC_CKS_LO  0
`define CCT_CKS_DIV2   2'h0
`define CCT_CKS_DIV8   2'h1
`define CCT_CKS_DIV32  2'h2
`define CCT_CKS_EXT    2'h3

// compare_output_control fields
`define CCT_OC_SEL     4
`define CCT_OC_OE_A    3
`define CCT_OC_OE_B    2
`define CCT_OC_LVL_A   1
`define CCT_OC_LVL_B   0

// timer_flag_status fields
`define CCT_FL_CLR_A   0

// prescaler taps for /2, /8, /32
`define CCT_TAP_DIV2   0
`define CCT_TAP_DIV8   2
`define CCT_TAP_DIV32  4

`endif

/* File: src/cct_timer.v */
`timescale 1ns/1ps
`include "cct_defs.vh"

module cct_timer (
  input  wire       mclk,
  input  wire       rst,
  input  wire       low_power,
  input  wire [3:0] bus_addr,
  input  wire       bus_wr,
  input  wire       bus_rd,
  input  wire [7:0] bus_wdata,
  output reg  [7:0] bus_rdata,
  input  wire       ext_clk_pin,
  input  wire       capture_pin_a,
  input  wire       capture_pin_b,
  input  wire       capture_pin_c,
  input  wire       capture_pin_d,
  output reg        compare_pin_a,
  output reg        compare_pin_b,
  output reg        irq_req
);

  ////////////////////////////////////////////////////////////////////////
  function edge_hit;
    input cur;
    input prev;
    input rising;
    begin
      edge_hit = rising ? (cur & ~prev) : (~cur & prev);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  reg  [7:0]  timer_irq_enable_r;
  reg  [7:0]  timer_flag_status_r;
  reg  [7:0]  timer_control_r;
  reg  [4:0]  compare_output_control_r;
  reg  [15:0] free_run_counter_r;
  reg  [15:0] compare_reg_a_r;
  reg  [15:0] compare_reg_b_r;
  reg  [15:0] capture_reg_a_r;
  reg  [15:0] capture_reg_b_r;
  reg  [15:0] capture_reg_c_r;
  reg  [15:0] capture_reg_d_r;
  reg  [7:0]  stage_r;
  reg  [7:1]  armed_r;
  reg  [4:0]  div_r;
  reg         div_prev_r;
  reg         ext_s1_r;
  reg         ext_s2_r;
  reg         ext_s3_r;
  reg  [3:0]  cap_s1_r;
  reg  [3:0]  cap_s2_r;
  reg  [3:0]  cap_s3_r;
  reg  [3:0]  pend_r;
  reg         lvl_a_r;
  reg         lvl_b_r;

  reg  [7:0]  rd_val;
  reg  [7:1]  flags_nxt;
  reg  [15:0] frc_nxt;

  wire        init = rst | low_power;
  wire [7:0]  octl_rst = `CCT_RST_OCTL; // top three bits are fixed, not stored
  wire [1:0]  cks  = timer_control_r[`CCT_TC_CKS_HI:`CCT_TC_CKS_LO];
  wire        oc_sel = compare_output_control_r[`CCT_OC_SEL];
  wire        buf_a  = timer_control_r[`CCT_TC_BUF_A];
  wire        buf_b  = timer_control_r[`CCT_TC_BUF_B];

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire wr_frc_h = bus_wr & (bus_addr == `CCT_A_FRC_H);
  wire wr_frc_l = bus_wr & (bus_addr == `CCT_A_FRC_L);
  wire wr_ocr_h = bus_wr & (bus_addr == `CCT_A_OCR_H);
  wire wr_ocr_l = bus_wr & (bus_addr == `CCT_A_OCR_L);
  wire wr_flags = bus_wr & (bus_addr == `CCT_A_FLAGS);
  wire rd_flags = bus_rd & (bus_addr == `CCT_A_FLAGS);
  wire rd_frc_h = bus_rd & (bus_addr == `CCT_A_FRC_H);
  wire [3:0] rd_cap_h;
  assign rd_cap_h[0] = bus_rd & (bus_addr == `CCT_A_ICA_H);
  assign rd_cap_h[1] = bus_rd & (bus_addr == `CCT_A_ICB_H);
  assign rd_cap_h[2] = bus_rd & (bus_addr == `CCT_A_ICC_H);
  assign rd_cap_h[3] = bus_rd & (bus_addr == `CCT_A_ICD_H);

  ////////////////////////////////////////////////////////////////////////
  // counter clock: prescaler taps counted on falling edge, so a
  // switch from a high tap to a low tap also yields one increment
  reg div_sel;
  always @* begin
    case (cks)
      `CCT_CKS_DIV2:  div_sel = div_r[`CCT_TAP_DIV2];
      `CCT_CKS_DIV8:  div_sel = div_r[`CCT_TAP_DIV8];
      `CCT_CKS_DIV32: div_sel = div_r[`CCT_TAP_DIV32];
      default:        div_sel = 1'b0;
    endcase
  end

  wire use_ext  = (cks == `CCT_CKS_EXT);
  wire int_tick = ~use_ext & div_prev_r & ~div_sel;
  wire ext_tick = use_ext & ext_s2_r & ~ext_s3_r;
  wire tick     = int_tick | ext_tick;

  ////////////////////////////////////////////////////////////////////////
  // compare; a lower-byte compare write suppresses its own match
  wire match_a = (free_run_counter_r == compare_reg_a_r);
  wire match_b = (free_run_counter_r == compare_reg_b_r);
  wire evt_a   = tick & match_a & ~(wr_ocr_l & ~oc_sel);
  wire evt_b   = tick & match_b & ~(wr_ocr_l & oc_sel);
  wire frc_clr = evt_a & timer_flag_status_r[`CCT_FL_CLR_A];
  // write beats increment, so no wrap then unless clear forces it
  wire ovf_evt = tick & (free_run_counter_r == `CCT_MAX_16) & (~wr_frc_l | frc_clr);

  always @* begin
    frc_nxt = free_run_counter_r;
    if (frc_clr)
      frc_nxt = `CCT_RST_16;
    else if (wr_frc_l)
      frc_nxt = {stage_r, bus_wdata};
    else if (tick)
      frc_nxt = free_run_counter_r + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // capture: a pending edge waits while a linked upper byte is read
  wire [3:0] edge_v;
  assign edge_v[0] = edge_hit(cap_s2_r[0], cap_s3_r[0], timer_control_r[`CCT_TC_EDGE_A]);
  assign edge_v[1] = edge_hit(cap_s2_r[1], cap_s3_r[1], timer_control_r[`CCT_TC_EDGE_A - 1]);
  assign edge_v[2] = edge_hit(cap_s2_r[2], cap_s3_r[2], timer_control_r[`CCT_TC_EDGE_A - 2]);
  assign edge_v[3] = edge_hit(cap_s2_r[3], cap_s3_r[3], timer_control_r[`CCT_TC_EDGE_A - 3]);

  wire [3:0] blk;
  assign blk[0] = rd_cap_h[0] | (buf_a & rd_cap_h[2]);
  assign blk[1] = rd_cap_h[1] | (buf_b & rd_cap_h[3]);
  assign blk[2] = rd_cap_h[2] | (buf_a & rd_cap_h[0]);
  assign blk[3] = rd_cap_h[3] | (buf_b & rd_cap_h[1]);

  wire [3:0] cap_req = edge_v | pend_r;
  wire [3:0] cap     = cap_req & ~blk;
  wire [3:0] pend_nx = cap_req & blk;

  ////////////////////////////////////////////////////////////////////////
  // flags: hardware set wins over a clear in the same cycle
  wire [7:1] set_v = {cap[0], cap[1], cap[2], cap[3], evt_a, evt_b, ovf_evt};
  wire [7:1] clr_v = wr_flags ? (armed_r & ~bus_wdata[7:1]) : 7'h00;

  always @* begin
    flags_nxt = set_v | (timer_flag_status_r[7:1] & ~clr_v);
  end

  ////////////////////////////////////////////////////////////////////////
  // read data mux
  always @* begin
    case (bus_addr)
      `CCT_A_IRQ_EN: rd_val = {timer_irq_enable_r[7:1], 1'b1};
      `CCT_A_FLAGS:  rd_val = timer_flag_status_r;
      `CCT_A_FRC_H:  rd_val = free_run_counter_r[15:8];
      `CCT_A_OCR_H:  rd_val = oc_sel ? compare_reg_b_r[15:8] : compare_reg_a_r[15:8];
      `CCT_A_OCR_L:  rd_val = oc_sel ? compare_reg_b_r[7:0] : compare_reg_a_r[7:0];
      `CCT_A_TCTL:   rd_val = timer_control_r;
      `CCT_A_OCTL:   rd_val = {`CCT_OCTL_FIXED, compare_output_control_r};
      `CCT_A_ICA_H:  rd_val = capture_reg_a_r[15:8];
      `CCT_A_ICB_H:  rd_val = capture_reg_b_r[15:8];
      `CCT_A_ICC_H:  rd_val = capture_reg_c_r[15:8];
      `CCT_A_ICD_H:  rd_val = capture_reg_d_r[15:8];
      default:       rd_val = stage_r; // lower bytes of counter and captures
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // synchronisers and prescaler; the first stages feed only the second
  always @(posedge mclk) begin
    if (init) begin
      ext_s1_r   <= 1'b0;
      ext_s2_r   <= 1'b0;
      ext_s3_r   <= 1'b0;
      cap_s1_r   <= 4'h0;
      cap_s2_r   <= 4'h0;
      cap_s3_r   <= 4'h0;
      div_r      <= 5'h00;
      div_prev_r <= 1'b0;
    end else begin
      ext_s1_r   <= ext_clk_pin;
      ext_s2_r   <= ext_s1_r;
      ext_s3_r   <= ext_s2_r;
      cap_s1_r   <= {capture_pin_d, capture_pin_c, capture_pin_b, capture_pin_a};
      cap_s2_r   <= cap_s1_r;
      cap_s3_r   <= cap_s2_r;
      div_r      <= div_r + 5'h01;
      div_prev_r <= div_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers, counter, captures
  always @(posedge mclk) begin
    if (init) begin
      timer_irq_enable_r       <= `CCT_RST_IRQ_EN;
      timer_flag_status_r      <= `CCT_RST_FLAGS;
      timer_control_r          <= `CCT_RST_TCTL;
      compare_output_control_r <= octl_rst[4:0];
      free_run_counter_r       <= `CCT_RST_16;
      compare_reg_a_r          <= `CCT_MAX_16;
      compare_reg_b_r          <= `CCT_MAX_16;
      capture_reg_a_r          <= `CCT_RST_16;
      capture_reg_b_r          <= `CCT_RST_16;
      capture_reg_c_r          <= `CCT_RST_16;
      capture_reg_d_r          <= `CCT_RST_16;
      stage_r                  <= 8'h00;
      armed_r                  <= 7'h00;
      pend_r                   <= 4'h0;
      bus_rdata                <= 8'h00;
    end else begin
      free_run_counter_r     <= frc_nxt;
      timer_flag_status_r[7:1] <= flags_nxt;
      pend_r                 <= pend_nx;
      if (bus_rd)
        bus_rdata <= rd_val;
      // staging latch, CPU must go upper then lower
      if (wr_frc_h | wr_ocr_h)
        stage_r <= bus_wdata;
      else if (rd_frc_h)
        stage_r <= free_run_counter_r[7:0];
      else if (rd_cap_h[0])
        stage_r <= capture_reg_a_r[7:0];
      else if (rd_cap_h[1])
        stage_r <= capture_reg_b_r[7:0];
      else if (rd_cap_h[2])
        stage_r <= capture_reg_c_r[7:0];
      else if (rd_cap_h[3])
        stage_r <= capture_reg_d_r[7:0];
      // read-as-one arming for the flag clear
      if (wr_flags)
        armed_r <= 7'h00;
      else if (rd_flags)
        armed_r <= timer_flag_status_r[7:1];
      else
        armed_r <= armed_r & timer_flag_status_r[7:1];
      if (bus_wr) begin
        case (bus_addr)
          `CCT_A_IRQ_EN: timer_irq_enable_r <= {bus_wdata[7:1], 1'b0};
          `CCT_A_FLAGS:  timer_flag_status_r[`CCT_FL_CLR_A] <= bus_wdata[`CCT_FL_CLR_A];
          `CCT_A_TCTL:   timer_control_r <= bus_wdata;
          `CCT_A_OCTL:   compare_output_control_r <= bus_wdata[4:0];
          `CCT_A_OCR_L: begin
            if (oc_sel)
              compare_reg_b_r <= {stage_r, bus_wdata};
            else
              compare_reg_a_r <= {stage_r, bus_wdata};
          end
          default: ;
        endcase
      end
      // capture A/B, with optional shift into C/D
      if (cap[0]) begin
        capture_reg_a_r <= free_run_counter_r;
        if (buf_a)
          capture_reg_c_r <= capture_reg_a_r;
      end
      if (cap[1]) begin
        capture_reg_b_r <= free_run_counter_r;
        if (buf_b)
          capture_reg_d_r <= capture_reg_b_r;
      end
      // in buffer mode C/D edges only flag, no load
      if (cap[2] & ~buf_a)
        capture_reg_c_r <= free_run_counter_r;
      if (cap[3] & ~buf_b)
        capture_reg_d_r <= free_run_counter_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compare pins and interrupt request
  wire lvl_a_nxt = evt_a ? compare_output_control_r[`CCT_OC_LVL_A] : lvl_a_r;
  wire lvl_b_nxt = evt_b ? compare_output_control_r[`CCT_OC_LVL_B] : lvl_b_r;

  always @(posedge mclk) begin
    if (init) begin
      lvl_a_r       <= 1'b0;
      lvl_b_r       <= 1'b0;
      compare_pin_a <= 1'b0;
      compare_pin_b <= 1'b0;
      irq_req       <= 1'b0;
    end else begin
      lvl_a_r       <= lvl_a_nxt;
      lvl_b_r       <= lvl_b_nxt;
      compare_pin_a <= compare_output_control_r[`CCT_OC_OE_A] & lvl_a_nxt;
      compare_pin_b <= compare_output_control_r[`CCT_OC_OE_B] & lvl_b_nxt;
      irq_req       <= |(flags_nxt & timer_irq_enable_r[7:1]);
    end
  end

endmodule

/* File: sim/cct_timer_sva.sv */
`timescale 1ns/1ps
`include "cct_defs.vh"
module cct_timer_sva (
  input wire       mclk,
  input wire       rst,
  input wire       low_power,
  input wire [3:0] bus_addr,
  input wire       bus_wr,
  input wire       bus_rd,
  input wire [7:0] bus_wdata,
  input wire [7:0] bus_rdata,
  input wire       ext_clk_pin,
  input wire       capture_pin_a,
  input wire       capture_pin_b,
  input wire       capture_pin_c,
  input wire       capture_pin_d,
  input wire       compare_pin_a,
  input wire       compare_pin_b,
  input wire       irq_req
);
  // shadows of written controls; the checker cannot see inside
  reg [7:0] oc_r;
  reg [7:0] ie_r;
  reg [7:0] tc_r;
  reg       rd_q;
  reg       rst_q;
  reg [3:0] ra_q;
  always @(posedge mclk) begin
    rd_q <= bus_rd;
    ra_q <= bus_addr;
    rst_q <= rst | low_power;
    if (rst | low_power) begin
      oc_r <= `CCT_RST_OCTL;
      ie_r <= `CCT_RST_IRQ_EN;
      tc_r <= `CCT_RST_TCTL;
    end else if (bus_wr) begin
      if (bus_addr == `CCT_A_OCTL) oc_r <= bus_wdata;
      if (bus_addr == `CCT_A_IRQ_EN) ie_r <= bus_wdata;
      if (bus_addr == `CCT_A_TCTL) tc_r <= bus_wdata;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || low_power);
  a_rdata_hold: assert property (!rd_q && !rst_q |-> $stable(bus_rdata)) else $error("read data moved");
  a_octl_fixed: assert property (rd_q && !rst_q && ra_q == `CCT_A_OCTL |-> bus_rdata[7:5] == 3'h7)
    else $error("compare control top bits not one");
  a_ien_bit0: assert property (rd_q && !rst_q && ra_q == `CCT_A_IRQ_EN |-> bus_rdata[0])
    else $error("irq enable bit0 not one");
  a_pin_a_off: assert property (!oc_r[3] && !$past(oc_r[3]) |-> !compare_pin_a)
    else $error("compare pin a driven while disabled");
  a_pin_b_off: assert property (!oc_r[2] && !$past(oc_r[2]) |-> !compare_pin_b)
    else $error("compare pin b driven while disabled");
  a_irq_off: assert property (ie_r[7:1] == 7'h00 && $past(ie_r[7:1]) == 7'h00 |-> !irq_req)
    else $error("irq without enable");
  a_cap_irq: assert property (tc_r[7] && ie_r[7] && $rose(capture_pin_a) |-> ##[3:6] irq_req)
    else $error("capture a irq missing");
  a_out_reset: assert property ($fell(rst) && !low_power |->
    !compare_pin_a && !compare_pin_b && !irq_req && bus_rdata == 8'h00) else $error("outputs not low after reset");
endmodule
bind cct_timer cct_timer_sva chk (.mclk(mclk), .rst(rst), .low_power(low_power), .bus_addr(bus_addr),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .ext_clk_pin(ext_clk_pin),
  .capture_pin_a(capture_pin_a), .capture_pin_b(capture_pin_b), .capture_pin_c(capture_pin_c),
  .capture_pin_d(capture_pin_d), .compare_pin_a(compare_pin_a), .compare_pin_b(compare_pin_b), .irq_req(irq_req));

/* File: sim/cct_cpu_model.sv */
`timescale 1ns/1ps
module cct_cpu_model (
  input  wire       mclk,
  output reg  [3:0] bus_addr,
  output reg        bus_wr,
  output reg        bus_rd,
  output reg  [7:0] bus_wdata,
  input  wire [7:0] bus_rdata
);
  initial begin
    bus_addr = 4'h0;
    bus_wr = 1'h0;
    bus_rd = 1'h0;
    bus_wdata = 8'h00;
  end
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      #2;
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'h1;
      @(posedge mclk);
      #2;
      bus_wr = 1'h0;
      bus_wdata = ~d;  // released data must not look held
    end
  endtask
  task rd(input [3:0] a, output [7:0] d);
    begin
      @(posedge mclk);
      #2;
      bus_addr = a;
      bus_rd = 1'h1;
      @(posedge mclk);
      #2;
      d = bus_rdata;
      bus_rd = 1'h0;
    end
  endtask
  task wr16(input [3:0] a, input [15:0] d);
    begin
      wr(a, d[15:8]);
      wr(a + 4'h1, d[7:0]);
    end
  endtask
  task rd16(input [3:0] a, output [15:0] d);
    begin
      rd(a, d[15:8]);
      rd(a + 4'h1, d[7:0]);
    end
  endtask
endmodule

/* File: sim/cct_timer_tb.sv */
`timescale 1ns/1ps
`include "cct_defs.vh"
module cct_timer_tb;
  reg         mclk;
  reg         rst;
  reg         low_power;
  reg         ext_clk_pin;
  reg         cap_a;
  reg         cap_b;
  reg         cap_c;
  reg         cap_d;
  wire [3:0]  bus_addr;
  wire        bus_wr;
  wire        bus_rd;
  wire [7:0]  bus_wdata;
  wire [7:0]  bus_rdata;
  wire        pin_a;
  wire        pin_b;
  wire        irq_req;
  integer     num_errors;
  integer     n_compared;
  integer     k;
  reg  [7:0]  b;
  reg  [15:0] w;
  reg  [15:0] v;
  cct_cpu_model cpu (.mclk(mclk), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
  cct_timer dut (.mclk(mclk), .rst(rst), .low_power(low_power), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .ext_clk_pin(ext_clk_pin),
    .capture_pin_a(cap_a), .capture_pin_b(cap_b), .capture_pin_c(cap_c), .capture_pin_d(cap_d),
    .compare_pin_a(pin_a), .compare_pin_b(pin_b), .irq_req(irq_req));
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      if (num_errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task waitc(input integer n);
    begin
      repeat (n) @(posedge mclk);
      #2;
    end
  endtask
  // pulse wider than 1.5 clocks so the synchroniser cannot miss it
  task ext_tick(input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        ext_clk_pin = 1'h1;
        waitc(4);
        ext_clk_pin = 1'h0;
        waitc(4);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  task t_reset;
    begin
      cpu.rd(`CCT_A_TCTL, b); chk(b, 8'h00);
      cpu.rd(`CCT_A_OCTL, b); chk(b, 8'he0);
      cpu.rd(`CCT_A_FLAGS, b); chk(b, 8'h00);
      cpu.rd16(`CCT_A_OCR_H, w); chk(w, 16'hffff);
      chk({pin_a, pin_b}, 2'h0);
    end
  endtask
  task t_regs;
    begin
      cpu.wr(`CCT_A_TCTL, 8'ha5); cpu.rd(`CCT_A_TCTL, b); chk(b, 8'ha5);
      cpu.wr(`CCT_A_OCTL, 8'h1f); cpu.rd(`CCT_A_OCTL, b); chk(b, 8'hff);
      cpu.wr(`CCT_A_OCTL, 8'h00); cpu.rd(`CCT_A_OCTL, b); chk(b, 8'he0);
      cpu.wr(`CCT_A_TCTL, 8'h5a);
      low_power = 1'h1;
      waitc(1);
      low_power = 1'h0;
      cpu.rd(`CCT_A_TCTL, b); chk(b, 8'h00);
    end
  endtask
  // read-to-read spacing is 260 cycles; one extra tick from phase
  task t_count;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        cpu.wr(`CCT_A_TCTL, k[7:0]);
        cpu.rd16(`CCT_A_FRC_H, w);
        waitc(256);
        cpu.rd16(`CCT_A_FRC_H, v);
        v = v - w;
        w = 16'd260 >> (1 + 2 * k);
        chk(v + 16'h0001 >= w && v <= w + 16'h0001, 16'h0001);
      end
    end
  endtask
  task t_frc;
    begin
      cpu.wr(`CCT_A_TCTL, 8'h03);
      cpu.wr16(`CCT_A_FRC_H, 16'haa55);
      cpu.rd16(`CCT_A_FRC_H, w); chk(w, 16'haa55);
      cpu.rd(`CCT_A_FRC_H, b);
      ext_tick(1);
      cpu.rd(`CCT_A_FRC_L, b); chk(b, 8'h55);
      cpu.rd16(`CCT_A_FRC_H, w); chk(w, 16'haa56);
    end
  endtask
  task t_cmp;
    begin
      cpu.wr(`CCT_A_OCTL, 8'h1a);
      cpu.wr16(`CCT_A_OCR_H, 16'h0020);
      cpu.wr(`CCT_A_OCTL, 8'h0a);
      cpu.wr16(`CCT_A_OCR_H, 16'h0010);
      cpu.rd16(`CCT_A_OCR_H, w); chk(w, 16'h0010);
      cpu.wr(`CCT_A_OCTL, 8'h1a);
      cpu.rd16(`CCT_A_OCR_H, w); chk(w, 16'h0020);
      cpu.wr(`CCT_A_OCTL, 8'h0a);
      cpu.wr16(`CCT_A_FRC_H, 16'h000f);
      ext_tick(1);
      chk(pin_a, 1'h0);
      ext_tick(1);
      chk(pin_a, 1'h1);
      cpu.rd(`CCT_A_FLAGS, b); chk(b & 8'h08, 8'h08);
      cpu.wr(`CCT_A_FLAGS, 8'h01);
      cpu.wr16(`CCT_A_FRC_H, 16'h000f);
      ext_tick(2);
      cpu.rd16(`CCT_A_FRC_H, w); chk(w, 16'h0000);
      cpu.wr(`CCT_A_OCTL, 8'h00);
      waitc(2);
      chk(pin_a, 1'h0);
      // channel b: drive high, then a low level must really pull it down
      cpu.wr(`CCT_A_OCTL, 8'h05);
      cpu.wr16(`CCT_A_FRC_H, 16'h0020);
      ext_tick(1);
      chk(pin_b, 1'h1);
      cpu.wr(`CCT_A_OCTL, 8'h04);
      cpu.wr16(`CCT_A_FRC_H, 16'h0020);
      ext_tick(1);
      chk(pin_b, 1'h0);
    end
  endtask
  task t_ovf;
    begin
      cpu.wr(`CCT_A_FLAGS, 8'h00);
      cpu.wr16(`CCT_A_FRC_H, 16'hffff);
      cpu.rd(`CCT_A_FLAGS, b); chk(b & 8'h02, 8'h00);
      ext_tick(1);
      cpu.rd16(`CCT_A_FRC_H, w); chk(w, 16'h0000);
      cpu.wr(`CCT_A_FLAGS, 8'h00);
      cpu.rd(`CCT_A_FLAGS, b); chk(b & 8'h02, 8'h02);
      cpu.wr(`CCT_A_FLAGS, 8'h00);
      cpu.rd(`CCT_A_FLAGS, b); chk(b & 8'h02, 8'h00);
      cpu.wr(`CCT_A_FLAGS, 8'hfe);
      cpu.rd(`CCT_A_FLAGS, b); chk(b & 8'h02, 8'h00);
      // match a at the wrap: clear and overflow in one tick
      cpu.wr(`CCT_A_OCTL, 8'h00);
      cpu.wr16(`CCT_A_OCR_H, 16'hffff);
      cpu.wr(`CCT_A_FLAGS, 8'h01);
      cpu.wr16(`CCT_A_FRC_H, 16'hffff);
      ext_tick(1);
      cpu.rd(`CCT_A_FLAGS, b); chk(b & 8'h0a, 8'h0a);
      cpu.rd16(`CCT_A_FRC_H, w); chk(w, 16'h0000);
    end
  endtask
  task t_cap;
    begin
      cpu.wr(`CCT_A_TCTL, 8'h8b);
      cpu.wr(`CCT_A_IRQ_EN, 8'h80);
      cpu.wr16(`CCT_A_FRC_H, 16'h0100);
      cap_a = 1'h1;
      waitc(8);
      chk(irq_req, 1'h1);
      cpu.rd16(`CCT_A_ICA_H, w); chk(w, 16'h0100);
      cpu.wr16(`CCT_A_FRC_H, 16'h0200);
      cap_a = 1'h0;
      waitc(8);
      cpu.rd16(`CCT_A_ICA_H, w); chk(w, 16'h0100);
      cap_a = 1'h1;
      waitc(8);
      cpu.rd16(`CCT_A_ICA_H, w); chk(w, 16'h0200);
      cpu.rd16(`CCT_A_ICC_H, w); chk(w, 16'h0100);
      cap_c = 1'h1;
      waitc(8);
      cap_c = 1'h0;
      waitc(8);
      cpu.rd(`CCT_A_FLAGS, b); chk(b & 8'h20, 8'h20);
      cpu.rd16(`CCT_A_ICC_H, w); chk(w, 16'h0100);
      cpu.wr(`CCT_A_TCTL, 8'h07);
      cpu.wr16(`CCT_A_FRC_H, 16'h0300);
      cap_b = 1'h1;
      cap_c = 1'h1;
      waitc(8);
      cap_b = 1'h0;
      cap_c = 1'h0;
      waitc(8);
      cpu.rd16(`CCT_A_ICC_H, w); chk(w, 16'h0300);
      cpu.rd16(`CCT_A_ICB_H, w); chk(w, 16'h0300);
      cpu.rd16(`CCT_A_ICD_H, w); chk(w, 16'h0000);
      // second b capture must push 0300 into d; a d edge only flags
      cpu.wr16(`CCT_A_FRC_H, 16'h0400);
      cap_b = 1'h1;
      cap_d = 1'h1;
      waitc(8);
      cap_b = 1'h0;
      cap_d = 1'h0;
      waitc(8);
      cpu.rd16(`CCT_A_ICB_H, w); chk(w, 16'h0400);
      cpu.rd16(`CCT_A_ICD_H, w); chk(w, 16'h0300);
      cpu.rd(`CCT_A_FLAGS, b); chk(b & 8'h10, 8'h10);
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    num_errors = 0;
    n_compared = 0;
    rst = 1'h1;
    low_power = 1'h0;
    ext_clk_pin = 1'h0;
    cap_a = 1'h0;
    cap_b = 1'h0;
    cap_c = 1'h0;
    cap_d = 1'h0;
    waitc(5);
    rst = 1'h0;
    t_reset;
    t_regs;
    t_count;
    t_frc;
    t_cmp;
    t_ovf;
    t_cap;
    test_done;
  end
endmodule
